// >>> rtl/mwl_top.sv
/*
  Microstep wave lookup: holds the incrementally coded quarter wave and its
  segment setup, expands it to a full period and produces two coil
  currents a quarter period apart on every microstep.
  Assumes the microstep counter comes from logic on ref_clk, moves by at
  most one per cycle and stands at zero when reset is released.
*/
// How it works
// RL1: Quarter wave of 256 extended to 1024
// RL2: Ten-bit counter indexes the full wave
// RL3: Increment bits in eight words 0x70-0x77
// RL4: Next entry adds slope or slope minus one
// RL5: Increments from -1 to +3 are allowed
// RL6: Four segments split by three borders
// RL7: Borders and slopes packed at 0x78
// RL8: Entries are eight bits, 256 per quarter
// RL9: Both coils start from programmable start values
// RL10: Both currents readable together at 0x7a
// RL11: Currents reload whenever counter reaches zero
// RL12: Coil B is coil A shifted 90 degrees
// RL13: Two segments need borders two, three 255
// RL14: Reset leaves a usable wave loaded
// RL15: Bit n sits in word n/32
// RL16: Start values at 0x7e bits 7:0, 23:16
// RL17: Coil B wave begins at position 256
// RL18: Later quadrants mirror and negate the quarter
// RL19: New setup takes effect at next zero
`timescale 1ns/100ps
module mwl_top (
  input  wire logic        ref_clk,            // 25 MHz system clock
  input  wire logic        nrst,               // Asynchronous reset, active low
  input  wire logic [9:0]  microstep_counter,  // Microstep position 0..1023
  input  wire logic [7:0]  reg_addr,           // Register offset
  input  wire logic [31:0] reg_wdata,          // Write data
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  output logic      [31:0] reg_rdata,          // Read data, cycle after strobe
  output logic      [8:0]  coil_a_current,     // Signed coil A current
  output logic      [8:0]  coil_b_current      // Signed coil B current
);

  // Reset release through two flops
  logic rst_meta_n_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n_q <= 1'b0;
      rst_n_q      <= 1'b0;
    end else begin
      rst_meta_n_q <= 1'b1;
      rst_n_q      <= rst_meta_n_q;
    end
  end

  // Register state
  logic [31:0]  tbl_shadow_q [mwl_pkg::WORDS];
  logic [255:0] tbl_shadow_flat;
  logic [255:0] tbl_active_q;
  logic [31:0]  seg_shadow_q;
  logic [31:0]  seg_active_q;
  logic [7:0]   start_a_q;
  logic [7:0]   start_b_q;
  logic [9:0]   count_q;
  logic [31:0]  rdata_q;
  logic [31:0]  rdata_d;

  // Address decode
  wire       tbl_hit   = reg_addr[7:3] == mwl_pkg::OFS_TABLE_FIRST[7:3];
  wire [2:0] tbl_idx   = reg_addr[2:0];
  wire       seg_hit   = reg_addr == mwl_pkg::OFS_SEG_CFG;
  wire       cnt_hit   = reg_addr == mwl_pkg::OFS_COUNT;
  wire       cur_hit   = reg_addr == mwl_pkg::OFS_CURRENT;
  wire       start_hit = reg_addr == mwl_pkg::OFS_START;
  wire       tbl_wr    = reg_wr && tbl_hit;
  wire       seg_wr    = reg_wr && seg_hit;
  wire       start_wr  = reg_wr && start_hit;

  // RL15: bit n lands at word n/32, bit n%32
  for (genvar g = 0; g < mwl_pkg::WORDS; g++) begin : g_flat
    assign tbl_shadow_flat[g*32 +: 32] = tbl_shadow_q[g];
  end

  // RL2: counter movement decides step or reload
  wire cnt_changed = microstep_counter != count_q;
  wire step_up     = microstep_counter == 10'(count_q + 10'h001);
  wire step_dn     = microstep_counter == 10'(count_q - 10'h001);
  // RL11: arriving at zero, from either side, reloads
  wire reload      = cnt_changed && (microstep_counter == 10'h000);
  wire step        = (step_up || step_dn) && !reload;

  // RL3: table words are write only storage
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < mwl_pkg::WORDS; i++) begin
        // RL14: preloaded wave
        tbl_shadow_q[i] <= mwl_pkg::TABLE_RST[i*32 +: 32];
      end
    end else if (tbl_wr) begin
      tbl_shadow_q[tbl_idx] <= reg_wdata;
    end
  end

  // RL7: segment setup, RL16: start values
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seg_shadow_q <= mwl_pkg::SEG_CFG_RST;
      start_a_q    <= mwl_pkg::START_A_RST;
      start_b_q    <= mwl_pkg::START_B_RST;
    end else begin
      if (seg_wr) begin
        seg_shadow_q <= reg_wdata;
      end
      if (start_wr) begin
        start_a_q <= reg_wdata[mwl_pkg::START_A_LSB +: mwl_pkg::ENTRY_W];
        start_b_q <= reg_wdata[mwl_pkg::START_B_LSB +: mwl_pkg::ENTRY_W];
      end
    end
  end

  // RL19: setup is taken over only at a zero crossing
  // Changing it mid period would break the running incremental sums.
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tbl_active_q <= mwl_pkg::TABLE_RST;
      seg_active_q <= mwl_pkg::SEG_CFG_RST;
    end else if (reload) begin
      tbl_active_q <= tbl_shadow_flat;
      seg_active_q <= seg_shadow_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= 10'h000;
    end else begin
      count_q <= microstep_counter;
    end
  end

  // Shared wave state to both trackers
  mwl_wave_if wave ();

  assign wave.inc_bits  = tbl_active_q;
  assign wave.seg_cfg   = seg_active_q;
  assign wave.old_count = count_q;
  assign wave.new_count = microstep_counter;
  assign wave.step      = step;
  assign wave.reload    = reload;

  // RL1: coil A reads the wave at the counter
  mwl_coil #(
    .POS_OFFSET (10'h000)
  ) u_coil_a (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n_q),
    .wave      (wave.coil),
    .start_val (start_a_q),
    .current   (coil_a_current)
  );

  // RL12: coil B reads the same wave a quarter ahead
  // RL17: so at count zero it reads wave position 256
  mwl_coil #(
    .POS_OFFSET (mwl_pkg::PHASE_B_OFFSET)
  ) u_coil_b (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n_q),
    .wave      (wave.coil),
    .start_val (start_b_q),
    .current   (coil_b_current)
  );

  // RL10: both currents in one word
  wire [31:0] cur_word = {7'h00, coil_b_current, 7'h00, coil_a_current};
  wire [31:0] cnt_word = {22'h000000, count_q};
  wire [31:0] start_word = {8'h00, start_b_q, 8'h00, start_a_q};

  // Write only and unmapped offsets read as zero
  assign rdata_d = !reg_rd  ? 32'h00000000
                 : cur_hit  ? cur_word
                 : cnt_hit  ? cnt_word
                 : start_hit ? start_word
                 : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_q);

  sequence s_tbl_write;
    reg_wr && tbl_hit;
  endsequence

  sequence s_seg_write;
    reg_wr && seg_hit;
  endsequence

  sequence s_wrap_up;
    count_q == 10'h3ff && microstep_counter == 10'h000;
  endsequence

  sequence s_peak_step;
    step_up && count_q == 10'h0ff;
  endsequence

  a_table_store: assert property ( // RL3
    s_tbl_write |=> tbl_shadow_q[$past(tbl_idx)] == $past(reg_wdata)
  ) else $error("increment word not stored");

  a_bit_layout: assert property ( // RL15
    s_tbl_write |=> tbl_shadow_flat[{$past(tbl_idx), 5'h00}] == $past(reg_wdata[0])
  ) else $error("increment bit in wrong position");

  a_cfg_store: assert property ( // RL7
    s_seg_write |=> seg_shadow_q[mwl_pkg::BORDER3_LSB +: mwl_pkg::BORDER_W]
                    == $past(reg_wdata[31:24])
  ) else $error("segment setup not stored");

  a_active_hold: assert property ( // RL19
    !reload |=> $stable(tbl_active_q) && $stable(seg_active_q)
  ) else $error("active setup changed away from a zero crossing");

  a_active_load: assert property ( // RL19
    reload |=> tbl_active_q == $past(tbl_shadow_flat)
  ) else $error("active table not taken over at zero");

  a_current_read: assert property ( // RL10
    reg_rd && cur_hit |=> reg_rdata[8:0] == $past(coil_a_current)
                          && reg_rdata[24:16] == $past(coil_b_current)
  ) else $error("current word read wrong");

  a_wrap_reload: assert property ( // RL11
    s_wrap_up |=> coil_a_current == {1'b0, $past(start_a_q)}
                  && coil_b_current == {1'b0, $past(start_b_q)}
  ) else $error("currents not reloaded at zero");

  a_peak_mirror: assert property ( // RL18
    s_peak_step |=> $stable(coil_a_current)
  ) else $error("coil A changed across its peak");

  a_b_quarter: assert property ( // RL12
    s_peak_step |=> coil_b_current == 9'(9'h000 - $past(coil_b_current))
  ) else $error("coil B did not cross zero a quarter ahead");

  a_read_once: assert property ( // RL10
    reg_rd ##1 !reg_rd |=> reg_rdata == 32'h00000000
  ) else $error("read data held past its cycle");

endmodule

// >>> rtl/mwl_pkg.sv
/*
  Constants of the microstep wave lookup block: register offsets, field
  positions, reset values and widths.
  Assumes every user references these as mwl_pkg::name, with no import.
*/
package mwl_pkg;

  // Widths
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned COUNT_W  = 10;
  localparam int unsigned ENTRY_W  = 8;
  localparam int unsigned CUR_W    = 9;
  localparam int unsigned QUARTER  = 256;
  localparam int unsigned WORDS    = 8;

  // Register offsets, as seen on the register port
  localparam logic [7:0] OFS_TABLE_FIRST = 8'h70;
  localparam logic [7:0] OFS_TABLE_LAST  = 8'h77;
  localparam logic [7:0] OFS_SEG_CFG     = 8'h78;
  localparam logic [7:0] OFS_COUNT       = 8'h79;
  localparam logic [7:0] OFS_CURRENT     = 8'h7a;
  localparam logic [7:0] OFS_START       = 8'h7e;

  // Segment configuration fields
  localparam int unsigned BORDER_W      = 8;
  localparam int unsigned SLOPE_W       = 2;
  localparam int unsigned BORDER3_LSB   = 24;
  localparam int unsigned BORDER2_LSB   = 16;
  localparam int unsigned BORDER1_LSB   = 8;
  localparam int unsigned SLOPE3_LSB    = 6;
  localparam int unsigned SLOPE2_LSB    = 4;
  localparam int unsigned SLOPE1_LSB    = 2;
  localparam int unsigned SLOPE0_LSB    = 0;

  // Start value and current value fields
  localparam int unsigned START_A_LSB   = 0;
  localparam int unsigned START_B_LSB   = 16;
  localparam int unsigned CUR_A_LSB     = 0;
  localparam int unsigned CUR_B_LSB     = 16;

  // Coil B runs a quarter period ahead of coil A
  localparam logic [9:0] PHASE_B_OFFSET = 10'h100;

  // Reset contents: a ready to use wave, border one at 128, slopes 2,1,1,1
  localparam logic [31:0]  SEG_CFG_RST = 32'hffff8056;
  localparam logic [7:0]   START_A_RST = 8'h00;
  localparam logic [7:0]   START_B_RST = 8'hf7;
  localparam logic [255:0] TABLE_RST   = {32'h00000000, 32'h00000000,
                                          32'h007fffff, 32'hffffffff,
                                          32'haaaaaaaa, 32'haaaaaaaa,
                                          32'haaaaaaaa, 32'haaaaaaaa};

endpackage

// >>> rtl/mwl_wave_if.sv
/*
  Shared wave state handed from the top of the lookup block to each coil
  tracker: active table bits, active segment setup and the counter step.
  Assumes one clock; all members are driven by the top only.
*/
`timescale 1ns/100ps
interface mwl_wave_if;
  logic [255:0] inc_bits;   // Active increment-select bits
  logic [31:0]  seg_cfg;    // Active segment borders and slopes
  logic [9:0]   old_count;  // Counter value before this cycle
  logic [9:0]   new_count;  // Counter value now
  logic         step;       // Counter moved by one, not onto zero
  logic         reload;     // Counter arrived at zero

  modport src  (output inc_bits, seg_cfg, old_count, new_count, step, reload);
  modport coil (input  inc_bits, seg_cfg, old_count, new_count, step, reload);
endinterface

// >>> rtl/mwl_coil.sv
/*
  One coil current tracker: follows the counter through the incrementally
  coded quarter wave and mirrors it into the full period.
  Assumes the counter moves by at most one per cycle and the wave interface
  is driven by mwl_top in the same clock domain.
*/
`timescale 1ns/100ps
module mwl_coil #(
  parameter logic [9:0] POS_OFFSET = 10'h000
) (
  input  wire logic       ref_clk,    // System clock
  input  wire logic       rst_n,      // Synchronised reset, active low
  mwl_wave_if.coil        wave,       // Shared wave state
  input  wire logic [7:0] start_val,  // Programmed entry at counter zero
  output logic      [8:0] current     // Signed coil current
);

  if (POS_OFFSET[7:0] != 8'h00) begin : g_chk
    $error("POS_OFFSET must be a whole quarter period");
  end

  // RL4: increment from slope and select bit
  function automatic logic [3:0] inc_at(input logic [7:0]   k,
                                        input logic [31:0]  cfg,
                                        input logic [255:0] bits);
    logic [1:0] slope;
    // RL6: four segments split by three borders
    if (k < cfg[mwl_pkg::BORDER1_LSB +: mwl_pkg::BORDER_W])
      slope = cfg[mwl_pkg::SLOPE0_LSB +: mwl_pkg::SLOPE_W];
    else if (k < cfg[mwl_pkg::BORDER2_LSB +: mwl_pkg::BORDER_W])
      slope = cfg[mwl_pkg::SLOPE1_LSB +: mwl_pkg::SLOPE_W];
    else if (k < cfg[mwl_pkg::BORDER3_LSB +: mwl_pkg::BORDER_W])
      slope = cfg[mwl_pkg::SLOPE2_LSB +: mwl_pkg::SLOPE_W];
    else
      slope = cfg[mwl_pkg::SLOPE3_LSB +: mwl_pkg::SLOPE_W];
    // RL5: result spans -1 to +3 in two's complement
    return {2'b00, slope} + {3'b000, bits[k]} - 4'h1;
  endfunction

  // RL18: odd quadrants run the quarter backwards
  function automatic logic [7:0] quarter_idx(input logic [9:0] p);
    return p[8] ? ~p[7:0] : p[7:0];
  endfunction

  // RL8: eight bit entries, 256 per quarter
  logic [7:0] ent_q;
  logic [7:0] ent_d;
  logic [8:0] cur_q;
  logic [8:0] cur_d;
  wire  [9:0] p_old    = 10'(wave.old_count + POS_OFFSET);
  wire  [9:0] p_new    = 10'(wave.new_count + POS_OFFSET);
  wire  [7:0] k_old    = quarter_idx(p_old);
  wire  [7:0] k_new    = quarter_idx(p_new);
  wire        fwd      = k_new == 8'(k_old + 8'h01);
  wire        back     = k_new == 8'(k_old - 8'h01);
  wire  [3:0] inc_fwd  = inc_at(k_old, wave.seg_cfg, wave.inc_bits);
  wire  [3:0] inc_back = 4'h0 - inc_at(k_new, wave.seg_cfg, wave.inc_bits);
  // At a quadrant edge the index repeats, so the entry holds
  wire  [3:0] delta    = fwd ? inc_fwd : (back ? inc_back : 4'h0);

  // RL9: entry seeded from start value
  // RL11: reload on zero, otherwise accumulate
  assign ent_d = wave.reload ? start_val
               : (wave.step ? 8'(ent_q + {{4{delta[3]}}, delta}) : ent_q);
  // RL18: second half period carries negative sign
  assign cur_d = p_new[9] ? 9'h000 - {1'b0, ent_d} : {1'b0, ent_d};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ent_q <= (POS_OFFSET == 10'h000) ? mwl_pkg::START_A_RST : mwl_pkg::START_B_RST;
      cur_q <= (POS_OFFSET == 10'h000) ? {1'b0, mwl_pkg::START_A_RST}
                                       : {1'b0, mwl_pkg::START_B_RST};
    end else if (wave.reload || wave.step) begin
      ent_q <= ent_d;
      cur_q <= cur_d;
    end
  end

  assign current = cur_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_reload_start: assert property ( // RL9
    wave.reload |=> ent_q == $past(start_val)
  ) else $error("entry not reloaded from start value");

  a_step_bounded: assert property ( // RL5
    (wave.step && !wave.reload) |=> (8'(ent_q - $past(ent_q)) inside
      {8'h00, 8'h01, 8'h02, 8'h03, 8'hff, 8'hfe, 8'hfd})
  ) else $error("entry moved by more than the allowed increment");

endmodule

// >>> tb/tb_microstep_wave_lookup.sv
/*
  Self-checking bench for mwl_top: register port, reset contents and both
  coil currents over full periods, checked against a closed-form wave model.
  Assumes the bench alone drives the counter and the register port.
*/
`timescale 1ns/100ps
module tb_microstep_wave_lookup;
  logic         ref_clk   = 1'b0;
  logic         nrst      = 1'b0;
  logic [9:0]   cnt       = 10'h000;
  logic [7:0]   reg_addr  = 8'h00;
  logic [31:0]  reg_wdata = 32'h00000000;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [31:0]  reg_rdata;
  logic [8:0]   cur_a;
  logic [8:0]   cur_b;
  int           err_total   = 0;
  int           checks_done = 0;
  int           cyc         = 0;
  // Shadow mirrors register writes; active copy follows it only at zero
  logic [255:0] sh_bits  = mwl_pkg::TABLE_RST;
  logic [255:0] act_bits = mwl_pkg::TABLE_RST;
  logic [31:0]  sh_cfg   = mwl_pkg::SEG_CFG_RST;
  logic [31:0]  act_cfg  = mwl_pkg::SEG_CFG_RST;
  logic [7:0]   st_a     = mwl_pkg::START_A_RST;
  logic [7:0]   st_b     = mwl_pkg::START_B_RST;
  logic [7:0]   act_sa   = mwl_pkg::START_A_RST;
  logic [7:0]   act_sb   = mwl_pkg::START_B_RST;

  always #20 ref_clk = ~ref_clk;

  mwl_top uut (
    .ref_clk           (ref_clk),
    .nrst              (nrst),
    .microstep_counter (cnt),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .coil_a_current    (cur_a),
    .coil_b_current    (cur_b)
  );

  task automatic give_verdict;
    $display("Checks: %0d, mismatches: %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] incr(input int k);
    logic [1:0] s;
    if (k < act_cfg[15:8]) s = act_cfg[1:0];
    else if (k < act_cfg[23:16]) s = act_cfg[3:2];
    else if (k < act_cfg[31:24]) s = act_cfg[5:4];
    else s = act_cfg[7:6];
    return {6'h00, s} + {7'h00, act_bits[k]} - 8'h01;
  endfunction

  function automatic logic [7:0] psum(input int k);
    logic [7:0] s;
    s = 8'h00;
    for (int j = 0; j < k; j++) s = s + incr(j);
    return s;
  endfunction

  // Coil B is anchored at the top of the quarter, so it counts down from 255
  function automatic logic [8:0] ecur(input logic [9:0] p, input logic is_b);
    int         k;
    logic [7:0] e;
    k = p[8] ? 255 - int'(p[7:0]) : int'(p[7:0]);
    e = is_b ? act_sb + psum(k) - psum(255) : act_sa + psum(k);
    return p[9] ? 9'h000 - {1'b0, e} : {1'b0, e};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    if (a >= 8'h70 && a <= 8'h77) sh_bits[32*(a-8'h70) +: 32] = d;
    if (a == mwl_pkg::OFS_SEG_CFG) sh_cfg = d;
    if (a == mwl_pkg::OFS_START) begin
      st_a = d[7:0];
      st_b = d[23:16];
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge ref_clk);
    #1;
    chk(reg_rdata, 32'h00000000);
  endtask

  task automatic mv(input logic [9:0] v);
    if (v == 10'h000 && cnt != 10'h000) begin
      act_bits = sh_bits;
      act_cfg  = sh_cfg;
      act_sa   = st_a;
      act_sb   = st_b;
    end
    @(posedge ref_clk);
    cnt <= v;
    @(posedge ref_clk);
    #1;
    chk({23'h0, cur_a}, {23'h0, ecur(v, 1'b0)});
    chk({23'h0, cur_b}, {23'h0, ecur(v + 10'h100, 1'b1)});
  endtask

  task automatic t_reset;
    chk({23'h0, cur_a}, {24'h0, mwl_pkg::START_A_RST});
    chk({23'h0, cur_b}, {24'h0, mwl_pkg::START_B_RST});
    rd_chk(mwl_pkg::OFS_CURRENT, {8'h00, mwl_pkg::START_B_RST, 16'h0000});
    rd_chk(mwl_pkg::OFS_START, {8'h00, mwl_pkg::START_B_RST, 8'h00, mwl_pkg::START_A_RST});
    rd_chk(mwl_pkg::OFS_TABLE_FIRST, 32'h00000000);
    rd_chk(8'h40, 32'h00000000);
    $display("Test reset done");
  endtask

  task automatic sweep;
    for (int i = 1; i < 1024; i++) begin
      mv(i[9:0]);
      if (i == 700) begin
        rd_chk(mwl_pkg::OFS_CURRENT, {7'h0, ecur(10'd956, 1'b1), 7'h0, ecur(10'd700, 1'b0)});
        rd_chk(mwl_pkg::OFS_COUNT, {22'h0, 10'd700});
      end
    end
    mv(10'h000);
  endtask

  task automatic t_default;
    sweep();
    for (int i = 1023; i >= 1000; i--) mv(i[9:0]);
    mv(10'h000);
    $display("Test default wave done");
  endtask

  task automatic t_new_table;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h70 + i[7:0], 32'h9e3779b9 ^ (32'h01010101 * i));
    end
    wr_reg(mwl_pkg::OFS_SEG_CFG, 32'hc878281e);
    wr_reg(mwl_pkg::OFS_START, 32'hab500010);
    wr_reg(mwl_pkg::OFS_CURRENT, 32'hffffffff);
    rd_chk(mwl_pkg::OFS_START, 32'h00500010);
    rd_chk(mwl_pkg::OFS_SEG_CFG, 32'h00000000);
    for (int i = 1; i <= 20; i++) mv(i[9:0]);
    mv(10'h000);
    sweep();
    mv(10'h001);
    mv(10'h002);
    // A jump that is not a single step must leave the currents alone
    @(posedge ref_clk);
    cnt <= 10'h007;
    @(posedge ref_clk);
    #1;
    chk({23'h0, cur_a}, {23'h0, ecur(10'h002, 1'b0)});
    mv(10'h000);
    $display("Test new table done");
  endtask

  // two segment setup, borders two and three at 255
  task automatic t_two_seg;
    wr_reg(mwl_pkg::OFS_SEG_CFG, 32'hffff4057);
    mv(10'h001);
    mv(10'h000);
    for (int i = 1; i <= 300; i++) mv(i[9:0]);
    mv(10'h000);
    $display("Test two segments done");
  endtask

  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset();
    t_default();
    t_new_table();
    t_two_seg();
    give_verdict();
  end
endmodule
